// ===== src/brd_remap_regs.vh
/*
 Constants for the bank 0 remap decoder: register indices, fields, reset values,
 remap codes, target bank numbers and window sizes.
 Assumes inclusion by the decoder modules only.
*/
// Operation
// - No flash, boot pin high clear: external ROM
// - Upper boot pin high: bank 9
// - Remap 1000 selects external SRAM bank
// - Remap 1001 selects external DRAM bank
// - Remap 1010 selects bank 10
// - Remap 11xx selects bank 2
// - Flash variant bank 0 halves follow swap
// - Flash variant ROM bank halves follow swap
// - No flash: whole ROM bank external
// - Half holds flash or 8 Mbyte ROM
// - New mapping within four clocks
// - Boot pins pick boot device
// - Bank 0 window is 128 Mbyte
// - Control write needs 0x3C unlock first
// - Select write needs 0x003C unlock first
// - Select bit 1 mirrors lower boot pin
`ifndef BRD_REMAP_REGS_VH
`define BRD_REMAP_REGS_VH
`define BRD_ADDR_CTRL 4'h0
`define BRD_ADDR_SEL 4'h4
`define BRD_UNLOCK_CTRL 16'h003c
`define BRD_UNLOCK_SEL 16'h003c
`define BRD_SWAP_BIT 0
`define BRD_MIRROR_BIT 1
`define BRD_REMAP_RST 4'h0
`define BRD_SWAP_RST 1'b0
`define BRD_BANK_BOOTLOAD 5'h09
`define BRD_BANK_SRAM 5'h1a
`define BRD_BANK_DRAM 5'h18
`define BRD_BANK_IRAM10 5'h0a
`define BRD_BANK_IRAM2 5'h02
`define BRD_BANK_ROM 5'h19
`define BRD_BANK_NONE 5'h1f
`define BRD_REMAP_SRAM 4'h8
`define BRD_REMAP_DRAM 4'h9
`define BRD_REMAP_IRAM10 4'ha
`define BRD_BANK0_TOP 27'h7ffffff
`define BRD_HALF_BIT 26
`define BRD_ROMBANK_BASE 32'hc8000000
`define BRD_ROMBANK_TOP 32'hcfffffff
`define BRD_ROMHALF_BIT 26
`define BRD_ROM_NOFLASH_TOP 24'hffffff
`define BRD_ROM_HALF_TOP 23'h7fffff
`define BRD_MAP_LATENCY 2
`endif

// ===== src/brd_sync2.v
/*
 Two flip-flop synchroniser for a pin level.
 Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
module brd_sync2 #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  // First stage read only by second
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= pinIn;
      syncOut <= stage1;
    end
  end
endmodule // brd_sync2

// ===== src/brd_regs.v
/*
 Remap control and ROM select registers with unlock protection.
 Assumes plain strobe bus on the same clock; read data one cycle after strobe.
*/
`timescale 1ns/100ps
`include "brd_remap_regs.vh"
module brd_regs (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] busAddr,
  input wire [15:0] busWrData,
  input wire busWrStb,
  input wire busRdStb,
  input wire bootPin0,
  output reg [15:0] busRdData,
  output reg [3:0] remapField,
  output reg romSwapBit
);
  reg ctrlUnlocked;
  reg selUnlocked;
  wire wrCtrl;
  wire wrSel;

  assign wrCtrl = busWrStb && (busAddr == `BRD_ADDR_CTRL);
  assign wrSel = busWrStb && (busAddr == `BRD_ADDR_SEL);

  // Unlock arms on key write, the next write to the register disarms; reads leave it armed
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      remapField <= `BRD_REMAP_RST;
      romSwapBit <= `BRD_SWAP_RST;
      ctrlUnlocked <= 1'b0;
      selUnlocked <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
      begin
        if (ctrlUnlocked)
        begin
          remapField <= busWrData[3:0];
          ctrlUnlocked <= 1'b0;
        end
        else
          ctrlUnlocked <= (busWrData == `BRD_UNLOCK_CTRL);
      end
      if (wrSel)
      begin
        if (selUnlocked)
        begin
          romSwapBit <= busWrData[`BRD_SWAP_BIT];
          selUnlocked <= 1'b0;
        end
        else
          selUnlocked <= (busWrData == `BRD_UNLOCK_SEL);
      end
    end
  end

  // Read mux, unmapped reads zero
  always @(posedge clk)
  begin
    if (sys_rst)
      busRdData <= 16'h0000;
    else if (busRdStb)
    begin
      if (busAddr == `BRD_ADDR_CTRL)
        busRdData <= {12'h000, remapField};
      else if (busAddr == `BRD_ADDR_SEL)
        busRdData <= {14'h0000, bootPin0, romSwapBit};
      else
        busRdData <= 16'h0000;
    end
    else
      busRdData <= 16'h0000;
  end
endmodule // brd_regs

// ===== src/brd_remap_decoder.v
/*
 Bank 0 remap decoder: picks the bank that answers processor addresses in
 bank 0 and orders flash and external ROM in the ROM bank.
 Assumes boot pins are static straps from outside the clock domain and
 that the bus master is on clk.
*/
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "brd_remap_regs.vh"
module brd_remap_decoder #(
  parameter HAS_FLASH = 1
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] busAddr,
  input wire [15:0] busWrData,
  input wire busWrStb,
  input wire busRdStb,
  output wire [15:0] busRdData,
  input wire [1:0] bootSelectPins,
  input wire [31:0] cpuAddr,
  input wire cpuValid,
  output reg bank0Hit,
  output reg [4:0] bank0Target,
  output reg bank0Reserved,
  output reg [26:0] bank0Offset,
  output reg romHit,
  output reg romToFlash,
  output reg [25:0] romOffset,
  output reg romOverrange
);
  wire [1:0] bootSync;
  wire [3:0] remapField;
  wire romSwapBit;
  reg [4:0] next_target;
  reg next_flashLow;
  reg next_b0Flash;
  reg [4:0] next_b0Target;
  wire swapMatch;
  wire inBank0;
  wire inRom;
  wire upperHalfB0;
  wire upperHalfRom;

  // Boot pins through two flops
  brd_sync2 #(
    .WIDTH(2)
  ) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(bootSelectPins),
    .syncOut(bootSync)
  );

  // Register file
  brd_regs uRegs (
    .clk(clk),
    .sys_rst(sys_rst),
    .busAddr(busAddr),
    .busWrData(busWrData),
    .busWrStb(busWrStb),
    .busRdStb(busRdStb),
    .bootPin0(bootSync[0]),
    .busRdData(busRdData),
    .remapField(remapField),
    .romSwapBit(romSwapBit)
  );

  // Flash ordering: flash low when swap equals lower boot pin
  assign swapMatch = (romSwapBit == bootSync[0]);

  // Bank 0 base selection from remap field and upper boot pin
  always @*
  begin
    next_target = `BRD_BANK_ROM;
    if (!remapField[3])
    begin
      if (bootSync[1])
        next_target = `BRD_BANK_BOOTLOAD;
      else
        next_target = `BRD_BANK_ROM;
    end
    else if (remapField[2])
      next_target = `BRD_BANK_IRAM2;
    else if (remapField[1:0] == 2'b00)
      next_target = `BRD_BANK_SRAM;
    else if (remapField[1:0] == 2'b01)
      next_target = `BRD_BANK_DRAM;
    else if (remapField[1:0] == 2'b10)
      next_target = `BRD_BANK_IRAM10;
    else
      next_target = `BRD_BANK_NONE;
  end

  // Decoded flags, registered for timing; mapping follows writes in 2 clocks
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      next_b0Target <= `BRD_BANK_ROM;
      next_flashLow <= 1'b0;
      next_b0Flash <= 1'b0;
    end
    else
    begin
      next_b0Target <= next_target;
      next_flashLow <= swapMatch;
      next_b0Flash <= (HAS_FLASH != 0) && !remapField[3] && !bootSync[1];
    end
  end

  assign inBank0 = (cpuAddr[31:27] == 5'h00);
  assign inRom = (cpuAddr >= `BRD_ROMBANK_BASE) && (cpuAddr <= `BRD_ROMBANK_TOP);
  assign upperHalfB0 = cpuAddr[`BRD_HALF_BIT];
  assign upperHalfRom = cpuAddr[`BRD_ROMHALF_BIT];

  // Registered routing outputs
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      bank0Hit <= 1'b0;
      bank0Target <= `BRD_BANK_ROM;
      bank0Reserved <= 1'b0;
      bank0Offset <= 27'h0000000;
      romHit <= 1'b0;
      romToFlash <= 1'b0;
      romOffset <= 26'h0000000;
      romOverrange <= 1'b0;
    end
    else
    begin
      bank0Hit <= cpuValid && inBank0;
      bank0Offset <= cpuAddr[26:0];
      bank0Reserved <= (next_b0Target == `BRD_BANK_NONE);
      bank0Target <= next_b0Target;
      romHit <= cpuValid && inRom;
      romOffset <= cpuAddr[25:0];
      // Flash and overrange flags only for a valid access that lands in a ROM half
      if (HAS_FLASH == 0)
      begin
        romToFlash <= 1'b0;
        romOverrange <= cpuValid && inRom && (cpuAddr[25:0] > {2'b00, `BRD_ROM_NOFLASH_TOP});
      end
      else if (next_b0Flash && inBank0)
      begin
        // Bank 0 halves alias the ROM bank halves
        romToFlash <= cpuValid && (upperHalfB0 != next_flashLow);
        romOverrange <= cpuValid && (upperHalfB0 == next_flashLow) &&
          (cpuAddr[25:0] > {3'b000, `BRD_ROM_HALF_TOP});
      end
      else
      begin
        romToFlash <= cpuValid && inRom && (upperHalfRom != next_flashLow);
        romOverrange <= cpuValid && inRom && (upperHalfRom == next_flashLow) &&
          (cpuAddr[25:0] > {3'b000, `BRD_ROM_HALF_TOP});
      end
    end
  end
endmodule // brd_remap_decoder

// ===== bench/brd_remap_decoder_monitor.sv
/* Port checker for the bank 0 remap decoder.
 Assumes one clock and a bind onto brd_remap_decoder. */
`timescale 1ns/100ps
module brd_checker (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] busAddr,
  input wire busRdStb,
  input wire [15:0] busRdData,
  input wire [1:0] bootSelectPins,
  input wire [31:0] cpuAddr,
  input wire cpuValid,
  input wire bank0Hit,
  input wire [4:0] bank0Target,
  input wire [26:0] bank0Offset,
  input wire romHit,
  input wire romToFlash
);
  // Routing and readback relations
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_hit; cpuValid |=> bank0Hit == ($past(cpuAddr[31:27]) == 5'h00); endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_idle; !cpuValid |=> !bank0Hit; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_off; cpuValid ##1 bank0Hit |-> bank0Offset == $past(cpuAddr[26:0]); endproperty
  a_off: assert property (p_off) else $error("offset");
  property p_rom; cpuValid |=> romHit == ($past(cpuAddr[31:27]) == 5'h19); endproperty
  a_rom: assert property (p_rom) else $error("rom");
  property p_flash; cpuValid ##1 romToFlash |-> romHit || bank0Hit; endproperty
  a_flash: assert property (p_flash) else $error("flash");
  property p_boot; bank0Hit && bank0Target == 5'h09 |-> bootSelectPins[1]; endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_mirror; busRdStb && busAddr == 4'h4 |=> busRdData[15:1] == {14'h0000, bootSelectPins[0]}; endproperty
  a_mirror: assert property (p_mirror) else $error("mirror");
  property p_rst; $fell(sys_rst) |-> bank0Target == 5'h19; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  // Main scenarios
  cover property (bank0Hit && bank0Target == 5'h1a);
  cover property (romHit && romToFlash);
  cover property (bank0Hit && bank0Target == 5'h09);
endmodule // brd_checker
bind brd_remap_decoder brd_checker u_chk (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busRdStb(busRdStb),
  .busRdData(busRdData), .bootSelectPins(bootSelectPins), .cpuAddr(cpuAddr), .cpuValid(cpuValid),
  .bank0Hit(bank0Hit), .bank0Target(bank0Target), .bank0Offset(bank0Offset), .romHit(romHit), .romToFlash(romToFlash));

// ===== bench/brd_cpu_model.sv
/* Processor side model issuing single-cycle accesses.
 Assumes go pulses for one cycle on clk. */
`timescale 1ns/100ps
module brd_cpu_model (
  input wire clk,
  input wire go,
  input wire [31:0] reqAddr,
  output reg cpuValid = 1'b0,
  output reg [31:0] cpuAddr = 32'h00000000
);
  // Launch a request, scramble the address when idle
  always @(posedge clk)
  begin
    cpuValid <= go;
    cpuAddr <= go ? reqAddr : ~cpuAddr;
  end
endmodule // brd_cpu_model

// ===== bench/tb_boot_bank0_remap_decoder.sv
/* Testbench for the bank 0 remap decoder.
 Assumes static boot pins; drives the flash and no-flash variants on the same stimulus. */
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_boot_bank0_remap_decoder;
  reg clk = 1'b0, sys_rst = 1'b1, busWrStb = 1'b0, busRdStb = 1'b0, go = 1'b0;
  reg [3:0] busAddr = 4'h0;
  reg [15:0] busWrData = 16'h0000;
  reg [1:0] bootSelectPins = 2'h0;
  reg [31:0] reqAddr = 32'h00000000;
  wire [15:0] busRdData;
  wire [31:0] cpuAddr;
  wire [4:0] bank0Target;
  wire cpuValid, bank0Hit, romHit, romToFlash;
  wire [25:0] romOffset;
  wire [4:0] nfTarget;
  wire bank0Reserved, romOverrange, nfToFlash, nfOverrange;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer i;
  // Remap codes and their banks
  localparam [53:0] MAPS = {4'h8, 5'h1a, 4'h9, 5'h18, 4'ha, 5'h0a, 4'hd, 5'h02, 4'hc, 5'h02, 4'hf, 5'h02};
  initial forever #4 clk = ~clk;
  brd_cpu_model u_cpu (.clk(clk), .go(go), .reqAddr(reqAddr), .cpuValid(cpuValid), .cpuAddr(cpuAddr));
  brd_remap_decoder #(.HAS_FLASH(1)) u_dut (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr),
    .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
    .bootSelectPins(bootSelectPins), .cpuAddr(cpuAddr), .cpuValid(cpuValid), .bank0Hit(bank0Hit),
    .bank0Target(bank0Target), .bank0Reserved(bank0Reserved), .bank0Offset(), .romHit(romHit),
    .romToFlash(romToFlash), .romOffset(romOffset), .romOverrange(romOverrange));
  // Variant without internal flash on the same stimulus
  brd_remap_decoder #(.HAS_FLASH(0)) u_nf (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr),
    .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(),
    .bootSelectPins(bootSelectPins), .cpuAddr(cpuAddr), .cpuValid(cpuValid), .bank0Hit(),
    .bank0Target(nfTarget), .bank0Reserved(), .bank0Offset(), .romHit(),
    .romToFlash(nfToFlash), .romOffset(), .romOverrange(nfOverrange));
  // Bus cycles and one processor access
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrStb <= 1'b1;
    @(posedge clk);
    busWrStb <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [15:0] e);
  begin
    @(posedge clk);
    busAddr <= a;
    busRdStb <= 1'b1;
    @(posedge clk);
    busRdStb <= 1'b0;
    #1 `CHK(busRdData, e)
  end
  endtask
  task acc(input [31:0] a, input [4:0] t, input f);
  begin
    repeat (4) @(posedge clk);
    go <= 1'b1;
    reqAddr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 `CHK({bank0Target, romToFlash}, {t, f})
    `CHK({nfTarget, nfToFlash}, {t, 1'b0})
  end
  endtask
  task reset_dut(input [1:0] pins);
  begin
    @(posedge clk);
    sys_rst <= 1'b1;
    bootSelectPins <= pins;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
  end
  endtask
  task complete_run;
  begin
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    reset_dut(2'b00);
    rd(4'h4, 16'h0000);
    acc(32'h00000000, 5'h19, 1'b1);
    acc(32'h04000000, 5'h19, 1'b0);
    acc(32'hc8000000, 5'h19, 1'b1);
    acc(32'hcc800000, 5'h19, 1'b0);
    `CHK({romOverrange, nfOverrange, bank0Reserved, romOffset}, {3'b100, 26'h0800000})
    wr(4'h4, 16'h0001);
    rd(4'h4, 16'h0000);
    wr(4'h4, 16'h003c);
    wr(4'h4, 16'h0003);
    rd(4'h4, 16'h0001);
    acc(32'h00000000, 5'h19, 1'b0);
    acc(32'hc8000000, 5'h19, 1'b0);
    wr(4'h0, 16'h0008);
    rd(4'h0, 16'h0000);
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(4'h0, 16'h003c);
      wr(4'h0, {12'h000, MAPS[i*9+5 +: 4]});
      repeat (4) @(posedge clk);
      #1 `CHK(bank0Target, MAPS[i*9 +: 5])
      rd(4'h0, {12'h000, MAPS[i*9+5 +: 4]});
      acc(32'h00000010, MAPS[i*9 +: 5], 1'b0);
    end
    reset_dut(2'b10);
    rd(4'h0, 16'h0000);
    acc(32'h00000000, 5'h09, 1'b0);
    complete_run;
  end
endmodule // tb_boot_bank0_remap_decoder
